/* logic/sync_measure_cfg.svh */
// register offsets, field positions, reset values and timing counts of the sync measurement block
`ifndef SYNC_MEASURE_CFG_SVH
`define SYNC_MEASURE_CFG_SVH
`define REG_FRAME_PERIOD_HIGH 8'h44
`define REG_FRAME_PERIOD_LOW 8'h45
`define REG_VERTICAL_PULSE_WIDTH 8'h46
`define REG_PIXEL_START_HIGH 8'h47
`define REG_PIXEL_START_LOW 8'h48
`define REG_PIXEL_COUNT_HIGH 8'h49
`define REG_PIXEL_COUNT_LOW 8'h4A
`define REG_FIRST_LINE_HIGH 8'h4B
`define REG_FIRST_LINE_LOW 8'h4C
`define REG_VISIBLE_LINES_HIGH 8'h4D
`define REG_VISIBLE_LINES_LOW 8'h4E
`define REG_TIMING_MEASURE_CONFIG 8'h4F
`define REG_PHASE_COMMAND 8'h50
`define REG_PHASE_COMMAND_STATUS 8'h51
`define REG_EVENT_STATUS 8'h60
`define REG_EVENT_MASK 8'h61
`define RST_PIXEL_START 10'h0F6
`define RST_PIXEL_COUNT 12'h500
`define RST_FIRST_LINE 10'h026
`define RST_VISIBLE_LINES 12'h400
`define RST_CONFIG 2'h0
`define CFG_UNITS_BIT 0
`define CFG_LINECOUNT_BIT 1
`define STATUS_BUSY_BIT 7
`define XTAL_UNIT_DIV 512
`define PHASE_BUSY_CYCLES 16'h0400
`define WINDOW_BUSY_CYCLES 16'h0010
`define EVT_FRAME_DONE 0
`define EVT_CMD_DONE 1
`define EVT_BAD_CMD 2
`endif

/* logic/sync_measure_pkg.sv */
// types of the sync measurement block
package sync_measure_pkg;
    typedef enum logic [2:0] {
        CMD_APPLY_PHASE = 3'h3,
        CMD_APPLY_WINDOW = 3'h4
    } phase_command_code_t;
    typedef enum {
        CMD_IDLE,
        CMD_RUN
    } cmd_state_t;
endpackage

/* logic/sync_timing_measure_and_window.sv */
// sync period measurement, active window registers and phase command engine
//
// Contract
// - frame period is 12 bits covering one full frame (two fields interlaced).
// - period equals 256 times high nibble plus low byte.
// - period and width are in lines or crystal/512 periods.
// - pulse width is 7 bits, true vertical sync only.
// - config bit 0 clear gives lines, set gives 512 crystal clocks.
// - config bit 1 selects integer line count or time-derived count.
// - pixel start: 10 bits, reset 0x0F6.
// - visible pixel count: 12 bits, reset 0x500.
// - line start: 10 bits, reset 0x026.
// - visible line count: 12 bits, reset 0x400.
// - each write to the command register launches its low three bits.
// - code 011 applies phase, 100 applies active window; others reserved.
// - status bit 7 is one while a phase or window command runs.
`timescale 1ns/1ps
`default_nettype none
`include "sync_measure_cfg.svh"
module sync_timing_measure_and_window #(
    parameter int XTAL_DIV = `XTAL_UNIT_DIV,
    parameter logic [15:0] PHASE_CYCLES = `PHASE_BUSY_CYCLES,
    parameter logic [15:0] WINDOW_CYCLES = `WINDOW_BUSY_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic xtal_tick,
    input wire logic horizontal_sync_output,
    input wire logic vertical_sync_output,
    input wire logic interlaced,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    output logic phase_apply,
    output logic window_apply
);
    import sync_measure_pkg::*;

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [1:0] hs_sync;
        logic [1:0] vs_sync;
        logic [1:0] xt_sync;
        logic [1:0] il_sync;
        logic hs_prev;
        logic vs_prev;
        logic xt_prev;
        logic field_odd;
        logic [8:0] xdiv;
        logic [11:0] line_cnt;
        // wide enough for a whole frame of crystal ticks before the divide
        logic [23:0] time_cnt;
        logic [11:0] hline_xt;
        logic [11:0] hline_meas;
        logic [6:0] width_cnt;
        logic [11:0] frame_period;
        logic [6:0] pulse_width;
        logic [9:0] pixel_start;
        logic [11:0] pixel_count;
        logic [9:0] first_line;
        logic [11:0] visible_lines;
        logic [1:0] config_bits;
        cmd_state_t cmd_state;
        logic [15:0] cmd_timer;
        logic cmd_is_phase;
        logic [2:0] evt_status;
        logic [2:0] evt_mask;
        logic [31:0] dat_o;
        logic ack;
        logic irq;
        logic phase_apply;
        logic window_apply;
    } state_t;

    state_t cur;
    state_t next_state;

    function automatic logic [7:0] byte_in(input logic [31:0] d);
        byte_in = d[7:0];
    endfunction

    // ********************************
    // logic
    // ********************************
    logic hs_rise;
    logic vs_rise;
    logic vs_fall;
    logic xt_rise;
    logic unit_tick;
    logic access;
    logic wr;
    logic [2:0] evt_set;
    logic [11:0] derived_lines;
    logic [7:0] wbyte;

    always_comb begin
        next_state = cur;
        wbyte = byte_in(wb_dat_i);
        // ********************************
        // synchronisers and edge detection
        // ********************************
        next_state.hs_sync = {cur.hs_sync[0], horizontal_sync_output};
        next_state.vs_sync = {cur.vs_sync[0], vertical_sync_output};
        next_state.xt_sync = {cur.xt_sync[0], xtal_tick};
        next_state.il_sync = {cur.il_sync[0], interlaced};
        next_state.hs_prev = cur.hs_sync[1];
        next_state.vs_prev = cur.vs_sync[1];
        next_state.xt_prev = cur.xt_sync[1];
        hs_rise = cur.hs_sync[1] && !cur.hs_prev;
        vs_rise = cur.vs_sync[1] && !cur.vs_prev;
        vs_fall = !cur.vs_sync[1] && cur.vs_prev;
        xt_rise = cur.xt_sync[1] && !cur.xt_prev;
        evt_set = 3'h0;
        // ********************************
        // measurement
        // ********************************
        // crystal/512 unit counter
        unit_tick = 1'b0;
        if (xt_rise) begin
            if (cur.xdiv == 9'(XTAL_DIV - 1)) begin
                next_state.xdiv = 9'h000;
                unit_tick = 1'b1;
            end else begin
                next_state.xdiv = cur.xdiv + 9'h001;
            end
        end
        // line period in crystal units, for the time-derived line count
        if (hs_rise) begin
            next_state.hline_meas = 12'h000;
            next_state.hline_xt = (cur.hline_meas == 12'h000) ? 12'h001 : cur.hline_meas;
        end else if (xt_rise && cur.hline_meas != 12'hFFF) begin
            next_state.hline_meas = cur.hline_meas + 12'h001;
        end
        if (hs_rise) begin
            next_state.line_cnt = cur.line_cnt + 12'h001;
        end
        if (xt_rise) begin
            next_state.time_cnt = cur.time_cnt + 24'h000001;
        end
        // width counts the main pulse only, broad sync level stays high through serrations
        if (cur.vs_sync[1]) begin
            if (cur.config_bits[`CFG_UNITS_BIT] ? unit_tick : hs_rise) begin
                if (cur.width_cnt != 7'h7F) begin
                    next_state.width_cnt = cur.width_cnt + 7'h01;
                end
            end
        end
        if (vs_rise) begin
            next_state.width_cnt = 7'h00;
        end
        if (vs_fall) begin
            next_state.pulse_width = cur.width_cnt;
        end
        // frame ticks over line ticks, rounded to the nearest whole line
        derived_lines = 12'((32'(cur.time_cnt) + 32'(cur.hline_xt) / 2) / 32'(cur.hline_xt));
        if (vs_rise) begin
            next_state.field_odd = !cur.field_odd;
            // interlaced frame spans two fields
            if (!cur.il_sync[1] || cur.field_odd) begin
                next_state.line_cnt = 12'h000;
                next_state.time_cnt = 24'h000000;
                next_state.field_odd = 1'b0;
                evt_set[`EVT_FRAME_DONE] = 1'b1;
                if (cur.config_bits[`CFG_UNITS_BIT]) begin
                    next_state.frame_period = 12'(cur.time_cnt / 24'(XTAL_DIV));
                end else if (!cur.config_bits[`CFG_LINECOUNT_BIT]) begin
                    next_state.frame_period = cur.line_cnt;
                end else begin
                    next_state.frame_period = derived_lines;
                end
            end
        end
        // the time counter advances per crystal tick; units divide on capture
        if (cur.config_bits[`CFG_UNITS_BIT] == 1'b0 && cur.config_bits[`CFG_LINECOUNT_BIT] == 1'b0) begin
            next_state.time_cnt = next_state.time_cnt;
        end
        // ********************************
        // command engine
        // ********************************
        next_state.phase_apply = 1'b0;
        next_state.window_apply = 1'b0;
        if (cur.cmd_state == CMD_RUN) begin
            if (cur.cmd_timer == 16'h0000) begin
                next_state.cmd_state = CMD_IDLE;
                evt_set[`EVT_CMD_DONE] = 1'b1;
                next_state.phase_apply = cur.cmd_is_phase;
                next_state.window_apply = !cur.cmd_is_phase;
            end else begin
                next_state.cmd_timer = cur.cmd_timer - 16'h0001;
            end
        end
        // ********************************
        // register bus
        // ********************************
        // wishbone slave, one wait state, ack drops the cycle after
        access = wb_cyc_i && wb_stb_i && !cur.ack;
        wr = access && wb_we_i && wb_sel_i[0];
        next_state.ack = access;
        next_state.dat_o = 32'h0000_0000;
        if (access && !wb_we_i) begin
            case (wb_adr_i)
                `REG_FRAME_PERIOD_HIGH: begin
                    next_state.dat_o[3:0] = cur.frame_period[11:8];
                end
                `REG_FRAME_PERIOD_LOW: begin
                    next_state.dat_o[7:0] = cur.frame_period[7:0];
                end
                `REG_VERTICAL_PULSE_WIDTH: begin
                    next_state.dat_o[6:0] = cur.pulse_width;
                end
                `REG_PIXEL_START_HIGH: begin
                    next_state.dat_o[1:0] = cur.pixel_start[9:8];
                end
                `REG_PIXEL_START_LOW: begin
                    next_state.dat_o[7:0] = cur.pixel_start[7:0];
                end
                `REG_PIXEL_COUNT_HIGH: begin
                    next_state.dat_o[3:0] = cur.pixel_count[11:8];
                end
                `REG_PIXEL_COUNT_LOW: begin
                    next_state.dat_o[7:0] = cur.pixel_count[7:0];
                end
                `REG_FIRST_LINE_HIGH: begin
                    next_state.dat_o[1:0] = cur.first_line[9:8];
                end
                `REG_FIRST_LINE_LOW: begin
                    next_state.dat_o[7:0] = cur.first_line[7:0];
                end
                `REG_VISIBLE_LINES_HIGH: begin
                    next_state.dat_o[3:0] = cur.visible_lines[11:8];
                end
                `REG_VISIBLE_LINES_LOW: begin
                    next_state.dat_o[7:0] = cur.visible_lines[7:0];
                end
                `REG_TIMING_MEASURE_CONFIG: begin
                    next_state.dat_o[1:0] = cur.config_bits;
                end
                `REG_PHASE_COMMAND_STATUS: begin
                    next_state.dat_o[`STATUS_BUSY_BIT] = (cur.cmd_state == CMD_RUN);
                end
                `REG_EVENT_STATUS: begin
                    next_state.dat_o[2:0] = cur.evt_status;
                end
                `REG_EVENT_MASK: begin
                    next_state.dat_o[2:0] = cur.evt_mask;
                end
                default: begin
                    next_state.dat_o = 32'h0000_0000;
                end
            endcase
        end
        if (wr) begin
            case (wb_adr_i)
                `REG_PIXEL_START_HIGH: begin
                    next_state.pixel_start[9:8] = wbyte[1:0];
                end
                `REG_PIXEL_START_LOW: begin
                    next_state.pixel_start[7:0] = wbyte;
                end
                `REG_PIXEL_COUNT_HIGH: begin
                    next_state.pixel_count[11:8] = wbyte[3:0];
                end
                `REG_PIXEL_COUNT_LOW: begin
                    next_state.pixel_count[7:0] = wbyte;
                end
                `REG_FIRST_LINE_HIGH: begin
                    next_state.first_line[9:8] = wbyte[1:0];
                end
                `REG_FIRST_LINE_LOW: begin
                    next_state.first_line[7:0] = wbyte;
                end
                `REG_VISIBLE_LINES_HIGH: begin
                    next_state.visible_lines[11:8] = wbyte[3:0];
                end
                `REG_VISIBLE_LINES_LOW: begin
                    next_state.visible_lines[7:0] = wbyte;
                end
                `REG_TIMING_MEASURE_CONFIG: begin
                    next_state.config_bits = wbyte[1:0];
                end
                `REG_EVENT_MASK: begin
                    next_state.evt_mask = wbyte[2:0];
                end
                `REG_PHASE_COMMAND: begin
                    // a write while busy restarts; host is expected to wait
                    case (wbyte[2:0])
                        CMD_APPLY_PHASE: begin
                            next_state.cmd_state = CMD_RUN;
                            next_state.cmd_timer = PHASE_CYCLES;
                            next_state.cmd_is_phase = 1'b1;
                        end
                        CMD_APPLY_WINDOW: begin
                            next_state.cmd_state = CMD_RUN;
                            next_state.cmd_timer = WINDOW_CYCLES;
                            next_state.cmd_is_phase = 1'b0;
                        end
                        default: begin
                            evt_set[`EVT_BAD_CMD] = 1'b1;
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end
        // ********************************
        // events
        // ********************************
        // write-one-to-clear, a set in the same cycle wins
        if (wr && wb_adr_i == `REG_EVENT_STATUS) begin
            next_state.evt_status = cur.evt_status & ~wbyte[2:0];
        end
        next_state.evt_status = next_state.evt_status | evt_set;
        next_state.irq = |(next_state.evt_status & next_state.evt_mask);
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur.hs_sync <= 2'h0;
            cur.vs_sync <= 2'h0;
            cur.xt_sync <= 2'h0;
            cur.il_sync <= 2'h0;
            cur.hs_prev <= 1'h0;
            cur.vs_prev <= 1'h0;
            cur.xt_prev <= 1'h0;
            cur.field_odd <= 1'h0;
            cur.xdiv <= 9'h000;
            cur.line_cnt <= 12'h000;
            cur.time_cnt <= 24'h000000;
            cur.hline_meas <= 12'h000;
            cur.width_cnt <= 7'h00;
            cur.frame_period <= 12'h000;
            cur.pulse_width <= 7'h00;
            cur.pixel_start <= `RST_PIXEL_START;
            cur.pixel_count <= `RST_PIXEL_COUNT;
            cur.first_line <= `RST_FIRST_LINE;
            cur.visible_lines <= `RST_VISIBLE_LINES;
            cur.config_bits <= `RST_CONFIG;
            cur.cmd_state <= CMD_IDLE;
            cur.cmd_timer <= 16'h0000;
            cur.cmd_is_phase <= 1'h0;
            cur.evt_status <= 3'h0;
            cur.evt_mask <= 3'h0;
            cur.dat_o <= 32'h0000_0000;
            cur.ack <= 1'h0;
            cur.irq <= 1'h0;
            cur.phase_apply <= 1'h0;
            cur.window_apply <= 1'h0;
            // one, so the time-derived count never divides by zero
            cur.hline_xt <= 12'h001;
        end else begin
            cur <= next_state;
        end
    end

    assign wb_dat_o = cur.dat_o;
    assign wb_ack_o = cur.ack;
    assign irq = cur.irq;
    assign phase_apply = cur.phase_apply;
    assign window_apply = cur.window_apply;
endmodule
`default_nettype wire

/* tb/sync_measure_asserts.sv */
// port checker of the sync measurement block
`timescale 1ns/1ps
`default_nettype none
module sync_measure_asserts #(
    parameter logic [15:0] PHASE_CYCLES = 16'h0400,
    parameter logic [15:0] WINDOW_CYCLES = 16'h0010
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq,
    input wire logic phase_apply,
    input wire logic window_apply
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic take, rd;
    logic [2:0] kind;
    logic [16:0] cnt;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd = take && !wb_we_i;
    // tracks the command in flight so each apply pulse is tied to its write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            kind <= 3'h0;
            cnt <= 17'h0;
        end else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h50) begin
            kind <= (wb_dat_i[2:0] inside {3'h3, 3'h4}) ? wb_dat_i[2:0] : 3'h0;
            cnt <= 17'h0;
        end else if (phase_apply || window_apply) begin
            kind <= 3'h0;
        end else begin
            cnt <= cnt + 17'h1;
        end
    end
    property p_ack; take |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    property p_phase; phase_apply |-> kind == 3'h3 && cnt >= 17'(PHASE_CYCLES)
        && cnt <= 17'(PHASE_CYCLES) + 17'h2; endproperty
    a_phase: assert property (p_phase) else $error("phase apply mistimed");
    property p_window; window_apply |-> kind == 3'h4 && cnt >= 17'(WINDOW_CYCLES)
        && cnt <= 17'(WINDOW_CYCLES) + 17'h2; endproperty
    a_window: assert property (p_window) else $error("window apply mistimed");
    property p_busy_set; rd && wb_adr_i == 8'h51 && kind != 3'h0 && cnt < 17'h3 |=> wb_dat_o[7]; endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy clear while running");
    property p_busy_idle; rd && wb_adr_i == 8'h51 && kind == 3'h0 |=> !wb_dat_o[7]; endproperty
    a_busy_idle: assert property (p_busy_idle) else $error("busy set while idle");
    property p_unmapped; rd && !(wb_adr_i inside {[8'h44:8'h51], 8'h60, 8'h61}) |=> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_period_hi; rd && wb_adr_i == 8'h44 |=> wb_dat_o[31:4] == 28'h0; endproperty
    a_period_hi: assert property (p_period_hi) else $error("period high too wide");
    property p_width; rd && wb_adr_i == 8'h46 |=> wb_dat_o[31:7] == 25'h0; endproperty
    a_width: assert property (p_width) else $error("pulse width too wide");
    property p_mask; take && wb_we_i && wb_adr_i == 8'h61 && wb_dat_i[7:0] == 8'h00
        |-> ##2 (!irq) [*3]; endproperty
    a_mask: assert property (p_mask) else $error("irq with mask clear");
endmodule
bind sync_timing_measure_and_window sync_measure_asserts #(
    .PHASE_CYCLES(PHASE_CYCLES), .WINDOW_CYCLES(WINDOW_CYCLES)
) sync_measure_asserts_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq), .phase_apply(phase_apply), .window_apply(window_apply)
);
`default_nettype wire

/* tb/video_sync_source.sv */
// video source model: free-running line sync, field sync and crystal clock
`timescale 1ns/1ps
`default_nettype none
module video_sync_source #(
    parameter int LINE = 8,
    parameter int LINES = 300,
    parameter int VW = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    output wire logic hs,
    output wire logic vs,
    output wire logic xt
);
    int pos;
    // field edges sit mid-line so no line pulse races them
    assign hs = (pos % LINE) < 2;
    assign vs = pos >= LINE / 2 && pos < LINE / 2 + VW * LINE;
    assign xt = pos[1];
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos <= 0;
        end else begin
            pos <= (pos == LINE * LINES - 1) ? 0 : pos + 1;
        end
    end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench of the sync measurement block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys, rst_n, interlaced, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic wb_ack_o, irq, phase_apply, window_apply, hs, vs, xt;
    int num_errors = 0, n_tests = 0, cycles = 0, np = 0, nw = 0, ep = 0, ew = 0;
    typedef struct packed {logic [7:0] a; logic w; logic [7:0] e;} row_t;
    row_t rows [16] = '{'{8'h47, 1'h0, 8'h00}, '{8'h48, 1'h0, 8'hF6}, '{8'h49, 1'h0, 8'h05},
        '{8'h4A, 1'h0, 8'h00}, '{8'h4B, 1'h0, 8'h00}, '{8'h4C, 1'h0, 8'h26}, '{8'h4D, 1'h0, 8'h04},
        '{8'h4E, 1'h0, 8'h00}, '{8'h4F, 1'h0, 8'h00}, '{8'h47, 1'h1, 8'h03}, '{8'h49, 1'h1, 8'h0F},
        '{8'h4B, 1'h1, 8'h03}, '{8'h4C, 1'h1, 8'hFF}, '{8'h4D, 1'h1, 8'h0F}, '{8'h4F, 1'h1, 8'h03},
        '{8'h70, 1'h1, 8'h00}};
    video_sync_source video_sync_source_inst (.clk_sys(clk_sys), .rst_n(rst_n), .hs(hs), .vs(vs), .xt(xt));
    sync_timing_measure_and_window #(.XTAL_DIV(8), .PHASE_CYCLES(16'h0008), .WINDOW_CYCLES(16'h0006))
    sync_timing_measure_and_window_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .xtal_tick(xt), .horizontal_sync_output(hs),
        .vertical_sync_output(vs), .interlaced(interlaced), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .phase_apply(phase_apply),
        .window_apply(window_apply));
    task automatic conclude();
        $display("errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %0h got %0h", nm, e, g);
        end
    endtask
    // measured figures may round by one unit
    task automatic chk_near(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if ((g + 1 >= e && g <= e + 1) !== 1'b1) begin
            num_errors++;
            $display("BAD %s exp %0d got %0d", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        // no cycle count assumed: only the bench timeout ends this wait
        forever begin
            @(posedge clk_sys);
            if (wb_ack_o === 1'b1) break;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    task automatic poll(output logic [31:0] q);
        for (int n = 0; n < 40; n++) begin
            bus(1'h0, 8'h51, 8'h00, q);
            if (q[7] === 1'b0) break;
        end
    endtask
    task automatic irq_step(input logic [7:0] a, input logic [7:0] d, input logic e);
        logic [31:0] q;
        bus(1'h1, a, d, q);
        repeat (3) @(posedge clk_sys);
        chk("irq", e, irq);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        np += (phase_apply === 1'b1);
        nw += (window_apply === 1'b1);
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        logic [31:0] q;
        logic [11:0] per;
        {rst_n, interlaced, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h00;
        {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h00, 4'h1, 32'h0};
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].w) bus(1'h1, rows[i].a, 8'hFF, q);
            bus(1'h0, rows[i].a, 8'h00, q);
            chk("reg", {24'h0, rows[i].e}, q);
        end
        for (int c = 0; c < 8; c++) begin
            bus(1'h1, 8'h50, 8'(c), q);
            bus(1'h0, 8'h51, 8'h00, q);
            chk("busy", (c == 3 || c == 4), q[7]);
            poll(q);
            repeat (12) @(posedge clk_sys);
            ep += (c == 3);
            ew += (c == 4);
            chk("apply", {ep[15:0], ew[15:0]}, {np[15:0], nw[15:0]});
            bus(1'h0, 8'h60, 8'h00, q);
            chk("event", (c == 3 || c == 4) ? 3'h2 : 3'h4, {q[2:1], 1'b0});
            bus(1'h1, 8'h60, 8'h06, q);
        end
        bus(1'h1, 8'h61, 8'h02, q);
        bus(1'h1, 8'h50, 8'h04, q);
        poll(q);
        irq_step(8'h61, 8'h02, 1'h1);
        irq_step(8'h61, 8'h00, 1'h0);
        irq_step(8'h61, 8'h02, 1'h1);
        irq_step(8'h60, 8'h02, 1'h0);
        for (int k = 0; k < 5; k++) begin
            interlaced <= (k == 4);
            bus(1'h1, 8'h4F, {6'h00, 2'(k)}, q);
            repeat (k == 4 ? 12000 : 7200) @(posedge clk_sys);
            @(posedge vs);
            repeat (50) @(posedge clk_sys);
            bus(1'h0, 8'h44, 8'h00, q);
            per = 12'h100 * q[3:0];
            bus(1'h0, 8'h45, 8'h00, q);
            per = per + q[7:0];
            chk_near("period", (k[0] ? 75 : 300) * (k == 4 ? 2 : 1), per);
            bus(1'h0, 8'h46, 8'h00, q);
            chk_near("width", k[0] ? 2 : 8, q);
            bus(1'h0, 8'h60, 8'h00, q);
            chk("frame", 32'h1, {31'h0, q[0]});
            bus(1'h1, 8'h60, 8'h01, q);
        end
        rst_n <= 1'h0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'h1;
        for (int i = 0; i < 9; i++) begin
            bus(1'h0, rows[i].a, 8'h00, q);
            chk("reset", {24'h0, rows[i].e}, q);
        end
        conclude();
    end
endmodule
`default_nettype wire
